// ---- hdl/bgpio_top.sv ----
// Banked general-purpose pin port with edge interrupts and DMA events
//
// Contract
// - Each pin is individually an input or an output.
// - An output pin drives its bit of the software-written output register.
// - An input pin's level is readable in the input register.
// - Pins group into banks of sixteen consecutive pins, bank zero pins 0-15.
// - 111 pins, numbered 0 to 110, in seven banks; the last is partial.
// - Pins 0 to 7 each have their own interrupt line.
// - Each of seven banks has one combined interrupt, raised by any enabled pin edge.
// - Each pin selects rising, falling or both edges independently.
// - Pins 0 to 7 each have their own DMA event line.
// - Each of seven banks has one combined DMA event output.
// - Ones written to set drive outputs high, to clear drive them low.
// - Input and output state are kept in separate registers.
// - A whole-word write replaces all output levels in that word.
// - Reading outputs returns commanded levels, not pin levels.
// - Input register shows the real pin level, also for output pins.
// - Each 32-bit word covers two adjacent banks, pins 0-31 and onward.
// - A per-bank enable gates that bank's interrupts and events.
`timescale 1ns/100ps
`default_nettype none

module bgpio_top
    import bgpio_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    // Pins
    input  wire logic [NUM_PINS-1:0]   i_pin_in,
    output logic      [NUM_PINS-1:0]   o_pin_out,
    output logic      [NUM_PINS-1:0]   o_pin_oe,
    // Register write port
    input  wire logic                  i_wr_en,
    input  wire bgpio_wr_kind_t        i_wr_kind,
    input  wire logic [PAIR_W-1:0]     i_wr_pair,
    input  wire logic [WORD_W-1:0]     i_wr_data,
    // Per-bank gate for interrupts and events
    input  wire logic [NUM_BANKS-1:0]  i_bank_irq_enable,
    // Register read-back
    output logic      [NUM_PINS-1:0]   o_dir,
    output logic      [NUM_PINS-1:0]   o_out_data,
    output logic      [NUM_PINS-1:0]   o_in_data,
    output logic      [NUM_PINS-1:0]   o_rise_en,
    output logic      [NUM_PINS-1:0]   o_fall_en,
    // Interrupts and DMA events
    output logic      [DED_PINS-1:0]   o_pin_irq,
    output logic      [NUM_BANKS-1:0]  o_bank_irq,
    output logic      [DED_PINS-1:0]   o_pin_evt,
    output logic      [NUM_BANKS-1:0]  o_bank_evt
);

    // All registered state of the port in one word; every output is a field
    // Direction bit high means the port drives the pin; reset leaves all inputs
    // Edge hits are pulses only; no sticky status, so no set-versus-clear race
    // A pin already high at reset release stays quiet: the detectors arm late
    typedef struct packed {
        logic [NUM_PINS-1:0]  dir;
        logic [NUM_PINS-1:0]  out;
        logic [NUM_PINS-1:0]  rise;
        logic [NUM_PINS-1:0]  fall;
        logic [NUM_PINS-1:0]  in_data;
        logic [DED_PINS-1:0]  pin_irq;
        logic [NUM_BANKS-1:0] bank_irq;
        logic [DED_PINS-1:0]  pin_evt;
        logic [NUM_BANKS-1:0] bank_evt;
    } bgpio_state_t;

    bgpio_state_t           state_r;
    bgpio_state_t           state_nxt;

    // Bank-aligned copies, padded up to whole banks
    logic [BANK_SPAN-1:0]   pin_pad;
    logic [BANK_SPAN-1:0]   rise_pad;
    logic [BANK_SPAN-1:0]   fall_pad;
    logic [BANK_SPAN-1:0]   level_all;
    logic [BANK_SPAN-1:0]   hit_all;

    // Write word placed in the selected one of the four word slots, then trimmed to the pins
    logic [PAD_W-1:0]       wmask_pad;
    logic [PAD_W-1:0]       wdata_pad;
    logic [NUM_PINS-1:0]    wmask;
    logic [NUM_PINS-1:0]    wdata;

    // Bank hits after the per-bank gate
    logic [NUM_BANKS-1:0]   bank_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Unpopulated top slot of the last bank is tied low, never triggers
    assign pin_pad  = {1'b0, i_pin_in};
    // Its edge selects are tied low as well, so no stray hit can appear
    assign rise_pad = {1'b0, state_r.rise};
    assign fall_pad = {1'b0, state_r.fall};

    // One detector per sixteen-pin bank
    // The gate sits before the event flops, so a bank disabled in the edge's
    // cycle loses that edge for good; enabling it later raises nothing late
    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
        bgpio_bank_if bif ();

        assign bif.pin_raw = pin_pad[g*BANK_W +: BANK_W];
        assign bif.rise_en = rise_pad[g*BANK_W +: BANK_W];
        assign bif.fall_en = fall_pad[g*BANK_W +: BANK_W];
        assign level_all[g*BANK_W +: BANK_W] = bif.level;
        assign hit_all[g*BANK_W +: BANK_W]   = bif.hit;
        assign bank_hit[g] = (|bif.hit) & i_bank_irq_enable[g];

        bgpio_edge_det u_det (
            .i_clk_sys (i_clk_sys),
            .i_rst     (i_rst),
            .i_ce      (i_ce),
            .bank      (bif.det)
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selected word lands on two adjacent banks; bits above pin 110 drop
    // Word slot three covers only pins 96 to 110, so its top bits fall off
    always_comb begin
        wmask_pad = '0;
        wdata_pad = '0;
        wmask_pad[{i_wr_pair, {WORD_LSB{1'b0}}} +: WORD_W] = {WORD_W{1'b1}};
        wdata_pad[{i_wr_pair, {WORD_LSB{1'b0}}} +: WORD_W] = i_wr_data;
    end

    // Mask and data trimmed to the populated pins
    assign wmask = wmask_pad[NUM_PINS-1:0];
    assign wdata = wdata_pad[NUM_PINS-1:0] & wmask;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: register writes, input capture, event pulses
    // Set and clear touch only the one-bits of the word, so two software
    // tasks can move different pins without a read-modify-write
    // A write while the clock enable is low is dropped without notice
    always_comb begin
        state_nxt = state_r;
        if (i_ce) begin
            if (i_wr_en) begin
                // One register touched per write, picked by the kind
                case (i_wr_kind)
                    WR_DIR: begin
                        state_nxt.dir = (state_r.dir & ~wmask) | wdata;
                    end
                    WR_OUT: begin
                        state_nxt.out = (state_r.out & ~wmask) | wdata;
                    end
                    WR_SET: begin
                        state_nxt.out = state_r.out | wdata;
                    end
                    WR_CLR: begin
                        state_nxt.out = state_r.out & ~wdata;
                    end
                    WR_RISE_SET: begin
                        state_nxt.rise = state_r.rise | wdata;
                    end
                    WR_RISE_CLR: begin
                        state_nxt.rise = state_r.rise & ~wdata;
                    end
                    WR_FALL_SET: begin
                        state_nxt.fall = state_r.fall | wdata;
                    end
                    WR_FALL_CLR: begin
                        state_nxt.fall = state_r.fall & ~wdata;
                    end
                    default: begin
                        state_nxt.dir = state_r.dir;
                    end
                endcase
            end
            // Synchronised pin level, whatever the direction
            // The detector's second flop feeds this, the input word is a third
            state_nxt.in_data  = level_all[NUM_PINS-1:0];
            // Dedicated lines share bank zero's gate
            state_nxt.pin_irq  = hit_all[DED_PINS-1:0]
                               & {DED_PINS{i_bank_irq_enable[0]}};
            state_nxt.pin_evt  = hit_all[DED_PINS-1:0]
                               & {DED_PINS{i_bank_irq_enable[0]}};
            // Bank lines OR every hit of the bank behind its gate
            state_nxt.bank_irq = bank_hit;
            state_nxt.bank_evt = bank_hit;
        end
    end

    // Synchronous reset overrides the clock enable, so a frozen port
    // still leaves reset in a known state
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r          <= '0;
            state_r.dir      <= DIR_RST;
            state_r.out      <= OUT_RST;
            state_r.rise     <= RISE_RST;
            state_r.fall     <= FALL_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state flops; output and input kept apart
    assign o_pin_out  = state_r.out;
    assign o_pin_oe   = state_r.dir;

    // Read-back: the output word shows what is commanded, the input word what
    // the pin really does, so wired logic on shared lines can be told apart
    assign o_dir      = state_r.dir;
    assign o_out_data = state_r.out;
    assign o_in_data  = state_r.in_data;
    assign o_rise_en  = state_r.rise;
    assign o_fall_en  = state_r.fall;

    // Interrupt and event lines carry the same pulse on separate wires
    assign o_pin_irq  = state_r.pin_irq;
    assign o_bank_irq = state_r.bank_irq;
    assign o_pin_evt  = state_r.pin_evt;
    assign o_bank_evt = state_r.bank_evt;

endmodule : bgpio_top

`default_nettype wire

// ---- hdl/bgpio_pkg.sv ----
// Shared constants and types for the banked general-purpose pin port
package bgpio_pkg;

    // Pin and bank geometry
    localparam int NUM_PINS  = 111;
    localparam int BANK_W    = 16;
    localparam int NUM_BANKS = 7;
    localparam int BANK_SPAN = NUM_BANKS * BANK_W;  // 112, last pin slot unpopulated
    localparam int DED_PINS  = 8;

    // Word layout of the write port: one word covers two banks
    localparam int WORD_W    = 32;
    localparam int NUM_PAIRS = 4;
    localparam int PAD_W     = NUM_PAIRS * WORD_W;
    localparam int PAIR_W    = 2;
    localparam int WORD_LSB  = 5;                   // Log2 of the word width

    // Input synchroniser depth and least pin pulse, in clock periods
    localparam int SYNC_STAGES   = 2;
    localparam int MIN_PULSE_CLK = 2;
    localparam int ARM_W         = SYNC_STAGES + 1;

    // Reset values
    localparam logic [NUM_PINS-1:0] DIR_RST  = 111'h0;  // All pins start as inputs
    localparam logic [NUM_PINS-1:0] OUT_RST  = 111'h0;
    localparam logic [NUM_PINS-1:0] RISE_RST = 111'h0;
    localparam logic [NUM_PINS-1:0] FALL_RST = 111'h0;

    // Kinds of register write on the control port
    typedef enum logic [2:0] {
        WR_DIR      = 3'h0,
        WR_OUT      = 3'h1,
        WR_SET      = 3'h2,
        WR_CLR      = 3'h3,
        WR_RISE_SET = 3'h4,
        WR_RISE_CLR = 3'h5,
        WR_FALL_SET = 3'h6,
        WR_FALL_CLR = 3'h7
    } bgpio_wr_kind_t;

endpackage : bgpio_pkg

// ---- hdl/bgpio_bank_if.sv ----
// Signals between the port core and one bank's edge detector
`timescale 1ns/100ps
`default_nettype none

interface bgpio_bank_if;
    import bgpio_pkg::*;
    logic [BANK_W-1:0] pin_raw;
    logic [BANK_W-1:0] rise_en;
    logic [BANK_W-1:0] fall_en;
    logic [BANK_W-1:0] level;
    logic [BANK_W-1:0] hit;

    modport ctrl (output pin_raw, output rise_en, output fall_en, input level, input hit);
    modport det  (input pin_raw, input rise_en, input fall_en, output level, output hit);
endinterface : bgpio_bank_if

`default_nettype wire

// ---- hdl/bgpio_edge_det.sv ----
// One bank of pin synchronisers and edge detectors
`timescale 1ns/100ps
`default_nettype none

module bgpio_edge_det
    import bgpio_pkg::*;
(
    // Clock, reset, enable
    input  wire logic   i_clk_sys,
    input  wire logic   i_rst,
    input  wire logic   i_ce,
    // Bank signals
    bgpio_bank_if.det   bank
);

    typedef struct packed {
        logic [BANK_W-1:0] sync1;
        logic [BANK_W-1:0] sync2;
        logic [BANK_W-1:0] prev;
        logic [ARM_W-1:0]  arm;
    } bgpio_det_state_t;

    bgpio_det_state_t state_r;
    bgpio_det_state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: two-flop synchroniser, then one delayed copy for edges
    always_comb begin
        state_nxt = state_r;
        if (i_ce) begin
            state_nxt.sync1 = bank.pin_raw;
            state_nxt.sync2 = state_r.sync1;
            state_nxt.prev  = state_r.sync2;
            state_nxt.arm   = {state_r.arm[ARM_W-2:0], 1'b1};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge hits; armed only once prev holds a real sample, so a pin high
    // at reset release does not look like a rising edge
    assign bank.level = state_r.sync2;
    assign bank.hit   = {BANK_W{state_r.arm[ARM_W-1]}}
                      & ((state_r.sync2 & ~state_r.prev & bank.rise_en)
                      |  (~state_r.sync2 & state_r.prev & bank.fall_en));

endmodule : bgpio_edge_det

`default_nettype wire

// ---- testbench/bgpio_chk.sv ----
// Port assertions for the banked pin port
`timescale 1ns/100ps
`default_nettype none
module bgpio_chk
    import bgpio_pkg::*;
(
    // Clock, reset, enable
    input wire logic                 i_clk_sys,
    input wire logic                 i_rst,
    input wire logic                 i_ce,
    // Pins and write port
    input wire logic [NUM_PINS-1:0]  i_pin_in,
    input wire logic                 i_wr_en,
    input wire bgpio_wr_kind_t       i_wr_kind,
    input wire logic [PAIR_W-1:0]    i_wr_pair,
    input wire logic [WORD_W-1:0]    i_wr_data,
    input wire logic [NUM_BANKS-1:0] i_bank_irq_enable,
    // Read-back and events
    input wire logic [NUM_PINS-1:0]  o_pin_out, o_pin_oe, o_dir, o_out_data,
    input wire logic [NUM_PINS-1:0]  o_in_data, o_rise_en, o_fall_en,
    input wire logic [DED_PINS-1:0]  o_pin_irq, o_pin_evt,
    input wire logic [NUM_BANKS-1:0] o_bank_irq, o_bank_evt
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Write to word 0 taken at this edge
    logic w0;
    assign w0 = i_ce && i_wr_en && i_wr_pair == 2'h0;
    property p_set; w0 && i_wr_kind == WR_SET |=>
        o_out_data[31:0] == ($past(o_out_data[31:0]) | $past(i_wr_data)); endproperty
    a_set: assert property (p_set) else $error("set write wrong");
    property p_clr; w0 && i_wr_kind == WR_CLR |=>
        o_out_data[31:0] == ($past(o_out_data[31:0]) & ~$past(i_wr_data)); endproperty
    a_clr: assert property (p_clr) else $error("clear write wrong");
    property p_out; w0 && i_wr_kind == WR_OUT |=> o_out_data[31:0] == $past(i_wr_data);
    endproperty
    a_out: assert property (p_out) else $error("word write wrong");
    property p_dir; w0 && i_wr_kind == WR_DIR |=> o_dir[31:0] == $past(i_wr_data); endproperty
    a_dir: assert property (p_dir) else $error("direction write wrong");
    property p_pin; o_pin_out == o_out_data && o_pin_oe == o_dir; endproperty
    a_pin: assert property (p_pin) else $error("pin drive differs");
    property p_evt; o_pin_irq == o_pin_evt && o_bank_irq == o_bank_evt; endproperty
    a_evt: assert property (p_evt) else $error("event differs from irq");
    // Three enabled edges with no reset between pin and register
    property p_sync; $past(i_ce) && $past(i_ce, 2) && $past(i_ce, 3) && !$past(i_rst)
        && !$past(i_rst, 2) && !$past(i_rst, 3) |-> o_in_data == $past(i_pin_in, 3);
    endproperty
    a_sync: assert property (p_sync) else $error("input latency wrong");
    property p_irq2; o_pin_irq[2] |-> (($rose(o_in_data[2]) && $past(o_rise_en[2]))
        || ($fell(o_in_data[2]) && $past(o_fall_en[2]))) ##1 !o_pin_irq[2]; endproperty
    a_irq2: assert property (p_irq2) else $error("pin pulse without edge");
    property p_bank; $fell(o_in_data[17]) && $past(o_fall_en[17])
        && $past(i_bank_irq_enable[1]) && $past(i_bank_irq_enable[1], 2) |-> o_bank_irq[1];
    endproperty
    a_bank: assert property (p_bank) else $error("bank pulse missing");
    property p_gate; !$past(i_bank_irq_enable[1]) && !$past(i_bank_irq_enable[1], 2)
        |-> !o_bank_irq[1]; endproperty
    a_gate: assert property (p_gate) else $error("gated bank pulsed");
    c_set: cover property (w0 && i_wr_kind == WR_SET);
    c_irq: cover property (o_pin_irq[2]);
    c_bank: cover property (o_bank_irq[6]);
endmodule : bgpio_chk
bind bgpio_top bgpio_chk u_chk (.i_clk_sys, .i_rst, .i_ce, .i_pin_in, .i_wr_en, .i_wr_kind,
    .i_wr_pair, .i_wr_data, .i_bank_irq_enable, .o_pin_out, .o_pin_oe, .o_dir, .o_out_data,
    .o_in_data, .o_rise_en, .o_fall_en, .o_pin_irq, .o_pin_evt, .o_bank_irq, .o_bank_evt);
`default_nettype wire

// ---- testbench/bgpio_pin_model.sv ----
// External devices on the pins, open-drain with pull-up
`timescale 1ns/100ps
`default_nettype none
module bgpio_pin_model
    import bgpio_pkg::*;
(
    // Level each external device wants; held two clocks at least
    input  wire logic [NUM_PINS-1:0] i_ext_lvl,
    // Port drive
    input  wire logic [NUM_PINS-1:0] i_pin_out,
    input  wire logic [NUM_PINS-1:0] i_pin_oe,
    output logic      [NUM_PINS-1:0] o_wire
);
    // Wired AND: a low from either side wins, released pins pull high
    assign o_wire = i_ext_lvl & (~i_pin_oe | i_pin_out);
endmodule : bgpio_pin_model
`default_nettype wire

// ---- testbench/bgpio_tb_top.sv ----
// Self-checking bench for the banked pin port
`timescale 1ns/100ps
`default_nettype none
module bgpio_tb_top
    import bgpio_pkg::*;
;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 ce = 1'b1;
    logic                 wr_en = 1'b0;
    bgpio_wr_kind_t       wr_kind = WR_DIR;
    logic [PAIR_W-1:0]    wr_pair = 2'h0;
    logic [WORD_W-1:0]    wr_data = 32'h0;
    logic [NUM_BANKS-1:0] bank_en = 7'h7f;
    logic [NUM_PINS-1:0]  ext = {NUM_PINS{1'b1}};
    logic [NUM_PINS-1:0]  pin_in, pin_out, pin_oe, dir, out_data, in_data, rise_en, fall_en;
    logic [DED_PINS-1:0]  pin_irq, pin_evt;
    logic [NUM_BANKS-1:0] bank_irq, bank_evt;
    int                   failures = 0;
    int                   checks = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    bgpio_top DUT (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_pin_in(pin_in),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_wr_en(wr_en), .i_wr_kind(wr_kind),
        .i_wr_pair(wr_pair), .i_wr_data(wr_data), .i_bank_irq_enable(bank_en), .o_dir(dir),
        .o_out_data(out_data), .o_in_data(in_data), .o_rise_en(rise_en), .o_fall_en(fall_en),
        .o_pin_irq(pin_irq), .o_bank_irq(bank_irq), .o_pin_evt(pin_evt), .o_bank_evt(bank_evt));
    bgpio_pin_model u_pins (.i_ext_lvl(ext), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .o_wire(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Strobe stays up so back-to-back writes never drop it mid-step
    task automatic wr(input bgpio_wr_kind_t k, input logic [1:0] p, input logic [31:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_kind = k;
        wr_pair = p;
        wr_data = d;
    endtask : wr
    task automatic idle(input int n);
        repeat (n) @(negedge clk) wr_en = 1'b0;
    endtask : idle
    // Move one pin, then count pulses over a window longer than the sync delay
    task automatic edge_on(input int p, input logic v, input int e_pin, input int e_bank);
        logic [7:0] np;
        logic [7:0] nb;
        np = 8'h0;
        nb = 8'h0;
        @(negedge clk) ext[p] = v;
        repeat (6) begin
            @(negedge clk);
            np += (p < DED_PINS) ? pin_irq[p % DED_PINS] : 1'b0;
            nb += bank_irq[p / BANK_W];
        end
        check("pin pulses", np, e_pin);
        check("bank pulses", nb, e_bank);
    endtask : edge_on
    task automatic give_verdict;
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_outputs;
        check("dir reset", dir, 0);
        check("edge reset", rise_en | fall_en, 0);
        wr(WR_DIR, 2'h0, 32'hffff_ffff);
        wr(WR_OUT, 2'h0, 32'h0000_00f0);
        wr(WR_SET, 2'h0, 32'h0000_0003);
        wr(WR_CLR, 2'h0, 32'h0000_0030);
        wr(WR_OUT, 2'h3, 32'hffff_ffff);
        wr(WR_SET, 2'h1, 32'h0000_0100);
        idle(1);
        check("out word0", out_data[31:0], 32'h0000_00c3);
        check("oe word0", pin_oe[31:0], 32'hffff_ffff);
        check("out bank6", out_data[110:96], 15'h7fff);
        check("out word1", out_data[63:32], 32'h0000_0100);
    endtask : t_outputs
    task automatic t_wired;
        ext[0] = 1'b0;
        ext[40] = 1'b0;
        idle(5);
        check("wired low", in_data[0], 1'b0);
        check("commanded", out_data[0], 1'b1);
        check("input pin", in_data[40], 1'b0);
    endtask : t_wired
    task automatic t_edges;
        wr(WR_DIR, 2'h0, 32'h0);
        wr(WR_RISE_SET, 2'h0, 32'h0000_0006);
        wr(WR_FALL_SET, 2'h0, 32'h0002_0004);
        wr(WR_RISE_SET, 2'h3, 32'h0000_0010);
        idle(8);
        edge_on(1, 1'b0, 0, 0);
        edge_on(1, 1'b1, 1, 1);
        edge_on(2, 1'b0, 1, 1);
        edge_on(17, 1'b0, 0, 1);
        edge_on(100, 1'b0, 0, 0);
        edge_on(100, 1'b1, 0, 1);
        bank_en = 7'h7d;
        edge_on(17, 1'b1, 0, 0);
        edge_on(17, 1'b0, 0, 0);
        bank_en = 7'h7f;
        wr(WR_RISE_CLR, 2'h0, 32'h0000_0006);
        wr(WR_FALL_CLR, 2'h0, 32'h0000_0004);
        idle(1);
        edge_on(2, 1'b1, 0, 0);
        edge_on(2, 1'b0, 0, 0);
    endtask : t_edges
    // Clock enable low: a write is dropped and a pin change must wait for it
    task automatic t_freeze;
        @(negedge clk) ce = 1'b0;
        wr(WR_SET, 2'h0, 32'h0000_0004);
        ext[5] = 1'b0;
        idle(4);
        check("frozen out", out_data[31:0], 32'h0000_00c3);
        check("frozen in", in_data[5], 1'b1);
        ce = 1'b1;
        wr(WR_SET, 2'h0, 32'h0000_0004);
        idle(4);
        check("thawed in", in_data[5], 1'b0);
        check("set after thaw", out_data[31:0], 32'h0000_00c7);
    endtask : t_freeze
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        idle(4);
        t_outputs();
        t_wired();
        t_edges();
        t_freeze();
        give_verdict();
    end
    // Tests need about 120 clocks; 4000 is a generous ceiling
    initial begin
        #20000;
        failures++;
        give_verdict();
    end
endmodule : bgpio_tb_top
`default_nettype wire
